//--- iosb_exec.sv
// Execution datapath for increment, OR, left shift and absolute jump
`timescale 1ns/100ps
`default_nettype none

module iosb_exec #(
  parameter int DATA_W  = iosb_pkg::DATA_W,
  parameter int ADDR_W  = iosb_pkg::ADDR_W,
  parameter int LIT_W   = iosb_pkg::LIT_W,
  parameter int PC_W    = iosb_pkg::PC_W,
  parameter int LATCH_W = iosb_pkg::LATCH_W
) (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   issue_valid,
  input  wire iosb_pkg::iosb_issue_t  issue,
  output logic                        issue_ready,
  output logic [6:0]                  reg_rd_addr,
  input  wire logic [7:0]             reg_rd_data,
  input  wire logic                   latch_wr_en,
  input  wire logic [6:0]             latch_wr_data,
  output logic [6:0]                  pc_high_latch,
  output iosb_pkg::iosb_reg_wr_t      reg_wr,
  output iosb_pkg::iosb_pc_load_t     pc_load,
  output logic                        nop_insert,
  output logic [7:0]                  acc,
  output logic                        zero_flag,
  output logic                        carry_flag
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 8 || ADDR_W != 7 || LIT_W != 11 || PC_W != 15 || LATCH_W != 7) begin : g_chk
    $error("iosb_exec: datapath widths are fixed by the instruction format");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  function automatic logic writes_reg(input iosb_pkg::iosb_op_t op);
    writes_reg = (op == iosb_pkg::IOSB_OP_INCREMENT_SKIP_ZERO)
              || (op == iosb_pkg::IOSB_OP_INCREMENT_REG)
              || (op == iosb_pkg::IOSB_OP_OR_ACC_WITH_REG)
              || (op == iosb_pkg::IOSB_OP_SHIFT_LEFT_LOGICAL_REG);
  endfunction : writes_reg

  // ----------------------------------------------------------------
  // Sequencer: one NOP cycle after a jump or a taken skip
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    IOSB_ST_RUN,
    IOSB_ST_NOP
  } iosb_state_t;

  iosb_state_t state_q;
  iosb_state_t state_d;

  logic                    take;
  logic [7:0]              acc_q;
  logic                    zero_q;
  logic                    carry_q;
  logic [6:0]              latch_q;
  iosb_pkg::iosb_reg_wr_t  reg_wr_q;
  iosb_pkg::iosb_pc_load_t pc_load_q;
  logic                    nop_q;

  logic [7:0] operand;
  logic [7:0] inc_res;
  logic [7:0] or_lit_res;
  logic [7:0] or_reg_res;
  logic [7:0] shl_res;
  logic       shl_carry;
  logic [7:0] result;
  logic       skip_taken;
  logic       is_jump;

  assign issue_ready = (state_q == IOSB_ST_RUN);
  assign take        = issue_valid && issue_ready;
  assign reg_rd_addr = issue.reg_addr;

  // Forward a register write still in flight so back-to-back use sees it
  always_comb begin
    operand = reg_rd_data;
    if (reg_wr_q.en && reg_wr_q.addr == issue.reg_addr) begin
      operand = reg_wr_q.data;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  assign inc_res    = 8'(operand + 8'h01);
  assign or_lit_res = acc_q | issue.literal[7:0];
  assign or_reg_res = acc_q | operand;
  assign shl_res    = {operand[6:0], 1'b0};
  assign shl_carry  = operand[7];

  assign is_jump    = (issue.op == iosb_pkg::IOSB_OP_JUMP_ABSOLUTE);
  assign skip_taken = (issue.op == iosb_pkg::IOSB_OP_INCREMENT_SKIP_ZERO)
                   && is_zero(inc_res);

  always_comb begin
    case (issue.op)
      iosb_pkg::IOSB_OP_INCREMENT_SKIP_ZERO:    result = inc_res;
      iosb_pkg::IOSB_OP_INCREMENT_REG:          result = inc_res;
      iosb_pkg::IOSB_OP_OR_LITERAL_INTO_ACC:    result = or_lit_res;
      iosb_pkg::IOSB_OP_OR_ACC_WITH_REG:        result = or_reg_res;
      iosb_pkg::IOSB_OP_SHIFT_LEFT_LOGICAL_REG: result = shl_res;
      default:                                  result = acc_q;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      IOSB_ST_RUN: begin
        if (take && (is_jump || skip_taken)) begin
          state_d = IOSB_ST_NOP;
        end
      end
      IOSB_ST_NOP: state_d = IOSB_ST_RUN;
      default:     state_d = IOSB_ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= IOSB_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Marks the inserted NOP cycle; fetch discards its prefetched word
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nop_q <= 1'b0;
    end else begin
      nop_q <= take && (is_jump || skip_taken);
    end
  end

  // ----------------------------------------------------------------
  // Working accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= iosb_pkg::ACC_RST;
    end else if (take) begin
      if (issue.op == iosb_pkg::IOSB_OP_OR_LITERAL_INTO_ACC) begin
        acc_q <= result;
      end else if (writes_reg(issue.op) && issue.dest == iosb_pkg::DEST_ACC) begin
        acc_q <= result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file write-back
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_wr_q <= '0;
    end else begin
      reg_wr_q.en   <= take && writes_reg(issue.op)
                    && issue.dest == iosb_pkg::DEST_REG;
      reg_wr_q.addr <= issue.reg_addr;
      reg_wr_q.data <= result;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_q <= iosb_pkg::FLAG_RST;
    end else if (take) begin
      case (issue.op)
        iosb_pkg::IOSB_OP_INCREMENT_REG,
        iosb_pkg::IOSB_OP_OR_LITERAL_INTO_ACC,
        iosb_pkg::IOSB_OP_OR_ACC_WITH_REG,
        iosb_pkg::IOSB_OP_SHIFT_LEFT_LOGICAL_REG: begin
          zero_q <= is_zero(result);
        end
        default: zero_q <= zero_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_q <= iosb_pkg::FLAG_RST;
    end else if (take && issue.op == iosb_pkg::IOSB_OP_SHIFT_LEFT_LOGICAL_REG) begin
      carry_q <= shl_carry;
    end
  end

  // ----------------------------------------------------------------
  // Program counter high latch and jump target
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= iosb_pkg::LATCH_RST;
    end else if (latch_wr_en) begin
      latch_q <= latch_wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_load_q <= '0;
    end else begin
      pc_load_q.load  <= take && is_jump;
      pc_load_q.value <= {latch_q[iosb_pkg::LATCH_HI_MSB:iosb_pkg::LATCH_HI_LSB],
                          issue.literal[iosb_pkg::JMP_LO_MSB:0]};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign acc           = acc_q;
  assign zero_flag     = zero_q;
  assign carry_flag    = carry_q;
  assign pc_high_latch = latch_q;
  assign reg_wr        = reg_wr_q;
  assign pc_load       = pc_load_q;
  assign nop_insert    = nop_q;

endmodule : iosb_exec

`default_nettype wire

//--- iosb_exec_bench.sv
// Self-checking bench for the execution datapath
`timescale 1ns/100ps
`default_nettype none
module iosb_exec_bench;
  localparam iosb_pkg::iosb_op_t SKP = iosb_pkg::IOSB_OP_INCREMENT_SKIP_ZERO;
  localparam iosb_pkg::iosb_op_t JMP = iosb_pkg::IOSB_OP_JUMP_ABSOLUTE;
  localparam iosb_pkg::iosb_op_t ORL = iosb_pkg::IOSB_OP_OR_LITERAL_INTO_ACC;
  localparam iosb_pkg::iosb_op_t INC = iosb_pkg::IOSB_OP_INCREMENT_REG;
  localparam iosb_pkg::iosb_op_t ORR = iosb_pkg::IOSB_OP_OR_ACC_WITH_REG;
  localparam iosb_pkg::iosb_op_t SHL = iosb_pkg::IOSB_OP_SHIFT_LEFT_LOGICAL_REG;
  logic                    core_clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic                    issue_valid = 1'b0;
  iosb_pkg::iosb_issue_t   issue = '0;
  logic                    latch_wr_en = 1'b0;
  logic [6:0]              latch_wr_data = 7'h00;
  logic                    ld_en = 1'b0;
  logic [6:0]              ld_addr = 7'h00;
  logic [7:0]              ld_data = 8'h00;
  logic                    issue_ready, nop_insert, zero_flag, carry_flag;
  logic [6:0]              reg_rd_addr, pc_high_latch;
  logic [7:0]              reg_rd_data, acc;
  iosb_pkg::iosb_reg_wr_t  reg_wr;
  iosb_pkg::iosb_pc_load_t pc_load;
  logic [7:0]              init_v [8] = '{8'hff, 8'h41, 8'h81, 8'h81, 8'h80, 8'h40, 8'hff, 8'h10};
  int                      miscompares = 0;
  int                      n_tests = 0;
  always #5 core_clk = ~core_clk;
  iosb_exec u_iosb_exec (.core_clk(core_clk), .arst_n(arst_n), .issue_valid(issue_valid),
    .issue(issue), .issue_ready(issue_ready), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .latch_wr_en(latch_wr_en), .latch_wr_data(latch_wr_data),
    .pc_high_latch(pc_high_latch), .reg_wr(reg_wr), .pc_load(pc_load),
    .nop_insert(nop_insert), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag));
  iosb_regfile u_iosb_regfile (.core_clk(core_clk), .rd_addr(reg_rd_addr),
    .rd_data(reg_rd_data), .wr(reg_wr), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data));
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  // Offer one instruction at a falling edge and hold it until taken
  task automatic run(input iosb_pkg::iosb_op_t op, input logic [6:0] a, input logic d,
                     input logic [10:0] k);
    int n;
    issue_valid = 1'b1;
    issue = '{op, a, d, k};
    n = 0;
    while (issue_ready !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    cmp_bit(issue_ready, 1'b1);
    @(negedge core_clk);
  endtask : run
  task automatic test_done;
    $display("Tests %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    #100us;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    cmp_val(acc, 8'h00);
    cmp_bit(issue_ready, 1'b1);
    for (int i = 0; i < 8; i++) begin
      ld_en = 1'b1;
      ld_addr = 7'(i + 3);
      ld_data = init_v[i];
      @(negedge core_clk);
    end
    ld_en = 1'b0;
    latch_wr_en = 1'b1;
    latch_wr_data = 7'h55;
    @(negedge core_clk);
    latch_wr_en = 1'b0;
    cmp_val(pc_high_latch, 7'h55);
    run(ORL, 7'h00, 1'b0, 11'h700);
    cmp_val(acc, 8'h00);
    cmp_bit(zero_flag, 1'b1);
    run(ORL, 7'h00, 1'b0, 11'h05a);
    cmp_val(acc, 8'h5a);
    cmp_bit(zero_flag, 1'b0);
    run(INC, 7'h03, 1'b1, 11'h000);
    cmp_val(reg_wr, {1'b1, 7'h03, 8'h00});
    cmp_bit(zero_flag, 1'b1);
    cmp_bit(nop_insert, 1'b0);
    run(INC, 7'h04, 1'b0, 11'h000);
    cmp_val(acc, 8'h42);
    cmp_bit(reg_wr.en, 1'b0);
    run(ORR, 7'h05, 1'b1, 11'h000);
    cmp_val(reg_wr, {1'b1, 7'h05, 8'hc3});
    run(ORR, 7'h05, 1'b0, 11'h000);
    cmp_val(acc, 8'hc3);
    cmp_bit(zero_flag, 1'b0);
    run(SHL, 7'h06, 1'b0, 11'h000);
    cmp_val(acc, 8'h02);
    cmp_bit(carry_flag, 1'b1);
    run(SHL, 7'h07, 1'b1, 11'h000);
    cmp_val(reg_wr, {1'b1, 7'h07, 8'h00});
    cmp_bit(zero_flag, 1'b1);
    run(SKP, 7'h09, 1'b1, 11'h000);
    cmp_val(reg_wr, {1'b1, 7'h09, 8'h00});
    cmp_bit(nop_insert, 1'b1);
    cmp_bit(issue_ready, 1'b0);
    run(SKP, 7'h0a, 1'b0, 11'h000);
    cmp_val(acc, 8'h11);
    cmp_bit(nop_insert, 1'b0);
    cmp_val({zero_flag, carry_flag}, 2'b11);
    run(SHL, 7'h08, 1'b0, 11'h000);
    cmp_val(acc, 8'h80);
    cmp_val({zero_flag, carry_flag}, 2'b00);
    run(JMP, 7'h00, 1'b0, 11'h7ff);
    cmp_val(pc_load, {1'b1, 15'h57ff});
    cmp_bit(nop_insert, 1'b1);
    cmp_bit(issue_ready, 1'b0);
    run(ORL, 7'h00, 1'b0, 11'h001);
    cmp_val(acc, 8'h81);
    cmp_bit(pc_load.load, 1'b0);
    issue_valid = 1'b0;
    @(negedge core_clk);
    test_done();
  end
endmodule : iosb_exec_bench
`default_nettype wire

//--- iosb_exec_properties.sv
// Port assertions for the execution datapath
`timescale 1ns/100ps
`default_nettype none
module iosb_exec_properties (
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  input wire logic                    issue_valid,
  input wire iosb_pkg::iosb_issue_t   issue,
  input wire logic                    issue_ready,
  input wire logic [7:0]              reg_rd_data,
  input wire logic                    latch_wr_en,
  input wire logic [6:0]              latch_wr_data,
  input wire logic [6:0]              pc_high_latch,
  input wire iosb_pkg::iosb_reg_wr_t  reg_wr,
  input wire iosb_pkg::iosb_pc_load_t pc_load,
  input wire logic                    nop_insert,
  input wire logic [7:0]              acc,
  input wire logic                    zero_flag,
  input wire logic                    carry_flag
);
  localparam iosb_pkg::iosb_op_t JMP = iosb_pkg::IOSB_OP_JUMP_ABSOLUTE;
  localparam iosb_pkg::iosb_op_t SKP = iosb_pkg::IOSB_OP_INCREMENT_SKIP_ZERO;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Taken instruction, and taken with no forwarded operand
  wire tk = issue_valid && issue_ready;
  wire fr = tk && !(reg_wr.en && reg_wr.addr == issue.reg_addr);
  a_jump_target: assert property (
    tk && issue.op == JMP && !latch_wr_en |=> pc_load.load
    && pc_load.value == {$past(pc_high_latch[6:3]), $past(issue.literal)})
    else $error("jump target wrong");
  a_jump_stall: assert property (
    tk && issue.op == JMP |=> nop_insert && !issue_ready ##1 issue_ready)
    else $error("jump stall wrong");
  a_jump_flags: assert property (
    tk && issue.op == JMP |=> $stable(zero_flag) && $stable(carry_flag))
    else $error("jump changed flags");
  a_skip_taken: assert property (
    fr && issue.op == SKP && reg_rd_data == 8'hff
    |=> nop_insert && !issue_ready && $stable(zero_flag))
    else $error("zero skip wrong");
  a_skip_passed: assert property (
    fr && issue.op == SKP && reg_rd_data != 8'hff |=> !nop_insert && issue_ready)
    else $error("skip on nonzero");
  a_or_literal: assert property (
    tk && issue.op == iosb_pkg::IOSB_OP_OR_LITERAL_INTO_ACC
    |=> acc == ($past(acc) | $past(issue.literal[7:0])) && zero_flag == (acc == 8'h00))
    else $error("or literal wrong");
  a_shift_carry: assert property (
    fr && issue.op == iosb_pkg::IOSB_OP_SHIFT_LEFT_LOGICAL_REG
    |=> carry_flag == $past(reg_rd_data[7]))
    else $error("shift carry wrong");
  a_inc_write: assert property (
    fr && issue.op == iosb_pkg::IOSB_OP_INCREMENT_REG && issue.dest
    |=> reg_wr.en && reg_wr.data == $past(reg_rd_data) + 8'h01 && !nop_insert)
    else $error("increment write wrong");
  a_or_register: assert property (
    fr && issue.op == iosb_pkg::IOSB_OP_OR_ACC_WITH_REG && issue.dest
    |=> reg_wr.en && reg_wr.data == ($past(acc) | $past(reg_rd_data))
    && zero_flag == (reg_wr.data == 8'h00))
    else $error("or register wrong");
  a_latch_load: assert property (
    latch_wr_en |=> pc_high_latch == $past(latch_wr_data))
    else $error("latch load wrong");
endmodule : iosb_exec_properties
bind iosb_exec iosb_exec_properties u_iosb_exec_properties (
  .core_clk(core_clk), .arst_n(arst_n), .issue_valid(issue_valid), .issue(issue),
  .issue_ready(issue_ready), .reg_rd_data(reg_rd_data), .latch_wr_en(latch_wr_en),
  .latch_wr_data(latch_wr_data), .pc_high_latch(pc_high_latch), .reg_wr(reg_wr),
  .pc_load(pc_load), .nop_insert(nop_insert), .acc(acc), .zero_flag(zero_flag),
  .carry_flag(carry_flag));
`default_nettype wire

//--- iosb_pkg.sv
// Constants and carrier types for the increment/or/shift/branch execution datapath
// How it works
// - Skip-increment writes accumulator or register, flags unchanged
// - Zero skip-increment result inserts one NOP cycle
// - Jump loads 11-bit immediate into PC 10:0
// - Jump fills PC 14:11 from latch 6:3
// - Jump takes two cycles, flags unchanged
// - OR literal into accumulator, update zero flag
// - Increment register to destination, update zero, no skip
// - OR accumulator with register to destination, update zero
// - Left shift: bit 7 to carry, 0 in
// - Shift result to destination, update carry and zero
// - PC high latch is seven bits wide
`default_nettype none

package iosb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int LIT_W   = 11;
  localparam int PC_W    = 15;
  localparam int LATCH_W = 7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int JMP_LO_MSB   = 10;
  localparam int LATCH_HI_MSB = 6;
  localparam int LATCH_HI_LSB = 3;

  // ----------------------------------------------------------------
  // Destination bit encoding and reset values
  // ----------------------------------------------------------------
  localparam logic       DEST_ACC   = 1'b0;
  localparam logic       DEST_REG   = 1'b1;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [6:0] LATCH_RST  = 7'h00;
  localparam logic       FLAG_RST   = 1'b0;

  // ----------------------------------------------------------------
  // Timing: extra cycles taken by two-cycle operations
  // ----------------------------------------------------------------
  localparam int EXTRA_CYCLES = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOSB_OP_NONE,
    IOSB_OP_INCREMENT_SKIP_ZERO,
    IOSB_OP_JUMP_ABSOLUTE,
    IOSB_OP_OR_LITERAL_INTO_ACC,
    IOSB_OP_INCREMENT_REG,
    IOSB_OP_OR_ACC_WITH_REG,
    IOSB_OP_SHIFT_LEFT_LOGICAL_REG
  } iosb_op_t;

  typedef struct packed {
    iosb_op_t    op;
    logic [6:0]  reg_addr;
    logic        dest;
    logic [10:0] literal;
  } iosb_issue_t;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } iosb_reg_wr_t;

  typedef struct packed {
    logic        load;
    logic [14:0] value;
  } iosb_pc_load_t;

endpackage : iosb_pkg

`default_nettype wire

//--- iosb_regfile.sv
// Data register file model facing the execution datapath
`timescale 1ns/100ps
`default_nettype none
module iosb_regfile (
  input  wire logic                   core_clk,
  input  wire logic [6:0]             rd_addr,
  output logic [7:0]                  rd_data,
  input  wire iosb_pkg::iosb_reg_wr_t wr,
  input  wire logic                   ld_en,
  input  wire logic [6:0]             ld_addr,
  input  wire logic [7:0]             ld_data
);
  logic [7:0] mem_q [128];
  // Combinational read in the cycle the address is offered
  assign rd_data = mem_q[rd_addr];
  always_ff @(posedge core_clk) begin
    if (ld_en)
      mem_q[ld_addr] <= ld_data;
    else if (wr.en)
      mem_q[wr.addr] <= wr.data;
  end
endmodule : iosb_regfile
`default_nettype wire
